//--- hw/battery_protector_config.sv
/*
 * Configuration and control registers of a two-cell battery protector, with its
 * sleep entry, overvoltage, overcurrent and short-circuit qualification.
 * Assumes a serial engine presents byte accesses on the core clock, analog
 * comparators report threshold crossings asynchronously, and the general pin
 * is open drain with an external pull.
 */
`timescale 1ns/1ns
`include "bpc_cfg.svh"
// What this block does
// - control register loads from nonvolatile copy at power-up; writes touch only shadow.
// - negative-blank enable zeroes small negative current readings; default off.
// - undervoltage with stable serial line for sleep delay enters sleep when enabled.
// - serial line low for sleep delay enters sleep when enabled.
// - opcode select picks 33h or 39h for the read-net-address command.
// - two-bit code selects undervoltage level 2.00, 2.30, 2.45 or 2.60 V.
// - general-pin power-switch enable makes the general pin a power-switch input.
// - line power-switch enable does likewise for the serial pin; ignored on two-wire.
// - overvoltage flagged when either cell stays above threshold for the delay.
// - seven-bit overvoltage code sets threshold (678 + 2 code) x 5 V / 1024.
// - two overcurrent bits select charge and discharge thresholds.
// - short-circuit bit selects 150 mV or 300 mV.
// - FET turns off only after overcurrent or short circuit outlasts its delay.
// - on two-wire parts the hash bit reads one while hashing.
// - pin control zero pulls the general pin low; reads return the pin level.
// - pin control forced to one at power-up and on sleep entry.
// - copy moves shadow into nonvolatile cells; recall reloads shadow from them.
module battery_protector_config
   import bpc_pkg::*;
#(
   parameter bit TWO_WIRE = 1'b0,
   parameter int SLEEP_DLY = `SLEEP_DLY_CYC,
   parameter int OV_DLY = `OV_DLY_CYC,
   parameter int OC_DLY = `OC_DLY_CYC,
   parameter int SC_DLY = `SC_DLY_CYC,
   parameter logic signed [15:0] BLANK_LIMIT = `BLANK_LIMIT
) (
   input wire logic i_core_clk,              // 100 MHz core clock
   input wire logic i_rstn,                  // async power-up reset, active low
   input wire logic i_wr_en,                 // register write strobe
   input wire logic i_rd_en,                 // register read strobe
   input wire logic [7:0] i_addr,            // register byte address
   input wire logic [7:0] i_wdata,           // write data
   input wire logic i_copy,                  // copy shadow to nonvolatile pulse
   input wire logic i_recall,                // recall nonvolatile to shadow pulse
   input wire logic i_hash_busy,             // hash engine running
   input wire logic [15:0] i_current,        // signed current reading
   input wire logic i_line,                  // serial line pin level
   input wire logic i_general_pin,           // general pin level
   input wire cmp_s i_cmp,                   // comparator outcomes
   output logic [7:0] o_rdata,               // read data
   output logic o_rvalid,                    // read data valid pulse
   output logic [15:0] o_current,            // blanked current reading
   output logic [7:0] o_net_addr_opcode,     // accepted opcode
   output logic [1:0] o_uv_threshold_sel,    // undervoltage level code
   output logic [6:0] o_ov_threshold,        // overvoltage threshold code
   output logic [1:0] o_overcurrent_sel,     // overcurrent threshold code
   output logic o_short_circuit_sel,         // short-circuit threshold select
   output logic o_gpin_power_switch_en,      // general pin is power-switch input
   output logic o_line_power_switch_en,      // serial pin is power-switch input
   output logic o_general_pin_o,             // general pin output value
   output logic o_general_pin_oe,            // general pin pulled low
   output logic o_sleep,                     // device asleep
   output logic o_ov_flag,                   // overvoltage condition
   output logic o_fet_off                    // FET turned off by overcurrent or short
);
   pwr_state_e state_q, state_d;
   ctrl_s ctrl_q, ctrl_d, nv_ctrl_q, nv_ctrl_d;
   sense_gain_s sg_q, sg_d, nv_sg_q, nv_sg_d;
   logic [6:0] ov_q, ov_d, nv_ov_q, nv_ov_d;
   logic gpin_ctl_q, gpin_ctl_d;
   logic line_prev_q;
   logic [7:0] rdata_d;
   logic [15:0] cur_d;
   logic line_s, gpin_s;
   cmp_s cmp;
   logic low_hit, uv_hit, ov_hit, oc_hit, sc_hit;
   logic line_stable, sleep_entry, blank;

   // pins and comparators cross into the core domain
   bpc_sync2 #(.WIDTH($bits(cmp_s) + 2)) u_sync (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async({i_cmp, i_line, i_general_pin}),
      .o_sync({cmp, line_s, gpin_s})
   );

   assign line_stable = (line_s == line_prev_q);

   // sleep qualifiers
   bpc_persist #(.DELAY(SLEEP_DLY)) u_low (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond(!line_s && (state_q == ST_ACTIVE)),
      .o_hit(low_hit)
   );
   bpc_persist #(.DELAY(SLEEP_DLY)) u_uv (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond(line_stable && cmp.avg_under_uv && (state_q == ST_ACTIVE)),
      .o_hit(uv_hit)
   );

   // protection qualifiers
   bpc_persist #(.DELAY(OV_DLY)) u_ov (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond(cmp.cell1_input_over || cmp.cell2_input_over),
      .o_hit(ov_hit)
   );
   bpc_persist #(.DELAY(OC_DLY)) u_oc (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond(cmp.chg_over_oc || cmp.dis_over_oc),
      .o_hit(oc_hit)
   );
   bpc_persist #(.DELAY(SC_DLY)) u_sc (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_cond(cmp.over_sc),
      .o_hit(sc_hit)
   );

   assign sleep_entry = (ctrl_q.undervoltage_sleep_en && uv_hit) ||
                        (ctrl_q.line_low_sleep_en && low_hit);

   // power state, shadow registers and nonvolatile image
   always_comb
   begin
      state_d = state_q;
      ctrl_d = ctrl_q;
      sg_d = sg_q;
      ov_d = ov_q;
      nv_ctrl_d = nv_ctrl_q;
      nv_sg_d = nv_sg_q;
      nv_ov_d = nv_ov_q;
      gpin_ctl_d = gpin_ctl_q;
      unique case (state_q)
         ST_BOOT:
         begin
            ctrl_d = nv_ctrl_q;
            sg_d = nv_sg_q;
            ov_d = nv_ov_q;
            state_d = ST_ACTIVE;
         end
         ST_ACTIVE:
         begin
            if (i_copy)
            begin
               nv_ctrl_d = ctrl_q;
               nv_sg_d = sg_q;
               nv_ov_d = ov_q;
            end
            if (i_recall)
            begin
               ctrl_d = nv_ctrl_q;
               sg_d = nv_sg_q;
               ov_d = nv_ov_q;
            end
            else if (i_wr_en)
            begin
               unique case (i_addr)
                  `ADDR_CONTROL: ctrl_d = ctrl_s'(i_wdata);
                  `ADDR_SENSE_GAIN: sg_d = sense_gain_s'(i_wdata);
                  `ADDR_OV_THRESH: ov_d = i_wdata[6:0];
                  `ADDR_FEATURE: gpin_ctl_d = i_wdata[`FEATURE_GPIN_BIT];
                  default: ;
               endcase
            end
            if (sleep_entry)
            begin
               state_d = ST_SLEEP;
               gpin_ctl_d = 1'b1;
            end
         end
         ST_SLEEP:
         begin
            gpin_ctl_d = 1'b1;
            if (!line_stable)
               state_d = ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_q <= ST_BOOT;
         ctrl_q <= ctrl_s'(`CONTROL_NV_RST);
         sg_q <= sense_gain_s'(`SENSE_GAIN_NV_RST);
         ov_q <= `OV_THRESH_NV_RST;
         nv_ctrl_q <= ctrl_s'(`CONTROL_NV_RST);
         nv_sg_q <= sense_gain_s'(`SENSE_GAIN_NV_RST);
         nv_ov_q <= `OV_THRESH_NV_RST;
         gpin_ctl_q <= `GPIN_CTL_RST;
         line_prev_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         sg_q <= sg_d;
         ov_q <= ov_d;
         nv_ctrl_q <= nv_ctrl_d;
         nv_sg_q <= nv_sg_d;
         nv_ov_q <= nv_ov_d;
         gpin_ctl_q <= gpin_ctl_d;
         line_prev_q <= line_s;
      end
   end

   // read mux; feature register shows live pin level and, on two-wire builds, hash activity
   always_comb
   begin
      rdata_d = '0;
      unique case (i_addr)
         `ADDR_CONTROL: rdata_d = ctrl_q;
         `ADDR_SENSE_GAIN: rdata_d = sg_q;
         `ADDR_OV_THRESH: rdata_d = {1'b0, ov_q};
         `ADDR_FEATURE:
         begin
            rdata_d[`FEATURE_HASH_BIT] = TWO_WIRE && i_hash_busy;
            rdata_d[`FEATURE_GPIN_BIT] = gpin_s;
         end
         default: rdata_d = `UNMAPPED_READ;
      endcase
   end

   // blanking of small negative readings
   always_comb
   begin
      blank = ctrl_q.negative_blank_en && ($signed(i_current) < 0) &&
              ($signed(i_current) >= -BLANK_LIMIT);
      cur_d = blank ? 16'h0000 : i_current;
   end

   // registered outputs
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
         o_current <= 16'h0000;
         o_net_addr_opcode <= `NET_ADDR_OPCODE_0;
         o_uv_threshold_sel <= 2'h0;
         o_ov_threshold <= 7'h00;
         o_overcurrent_sel <= 2'h0;
         o_short_circuit_sel <= 1'b0;
         o_gpin_power_switch_en <= 1'b0;
         o_line_power_switch_en <= 1'b0;
         o_general_pin_o <= 1'b0;
         o_general_pin_oe <= 1'b0;
         o_sleep <= 1'b0;
         o_ov_flag <= 1'b0;
         o_fet_off <= 1'b0;
      end
      else
      begin
         o_rvalid <= i_rd_en;
         if (i_rd_en)
            o_rdata <= rdata_d;
         o_current <= cur_d;
         o_net_addr_opcode <= ctrl_q.net_addr_opcode_sel ? `NET_ADDR_OPCODE_1 : `NET_ADDR_OPCODE_0;
         o_uv_threshold_sel <= ctrl_q.uv_threshold_sel;
         o_ov_threshold <= ov_q;
         o_overcurrent_sel <= sg_q.overcurrent_sel;
         o_short_circuit_sel <= sg_q.short_circuit_sel;
         o_gpin_power_switch_en <= ctrl_q.gpin_power_switch_en;
         o_line_power_switch_en <= ctrl_q.line_power_switch_en && !TWO_WIRE;
         o_general_pin_oe <= !gpin_ctl_q;
         o_sleep <= (state_q == ST_SLEEP);
         o_ov_flag <= ov_hit;
         o_fet_off <= oc_hit || sc_hit;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   boot_load_a: assert property ((state_q == ST_BOOT) |=> (ctrl_q == $past(nv_ctrl_q)))
      else $error("control not loaded from nonvolatile copy");
   blank_zero_a: assert property (blank |=> (o_current == 16'h0000))
      else $error("small negative current not blanked");
   sleep_cause_a: assert property ($rose(o_sleep) |-> $past(sleep_entry, 2))
      else $error("sleep entered without cause");
   uv_off_a: assert property ((state_q == ST_ACTIVE) && !ctrl_q.undervoltage_sleep_en && !low_hit |=>
                              (state_q != ST_SLEEP))
      else $error("undervoltage sleep while disabled");
   low_sleep_a: assert property ((state_q == ST_ACTIVE) && ctrl_q.line_low_sleep_en && low_hit |=>
                                 (state_q == ST_SLEEP) ##1 o_sleep)
      else $error("line low did not enter sleep");
   opcode_a: assert property (##1 o_net_addr_opcode ==
                              ($past(ctrl_q.net_addr_opcode_sel) ? `NET_ADDR_OPCODE_1 : `NET_ADDR_OPCODE_0))
      else $error("wrong net address opcode");
   ov_write_a: assert property ((state_q == ST_ACTIVE) && i_wr_en && !i_recall && (i_addr == `ADDR_OV_THRESH) |=>
                                ##1 (o_ov_threshold == $past(i_wdata[6:0], 2)))
      else $error("overvoltage code not applied");
   ov_flag_a: assert property ($rose(o_ov_flag) |-> $past(cmp.cell1_input_over || cmp.cell2_input_over))
      else $error("overvoltage flagged without cell over threshold");
   sc_short_a: assert property (cmp.over_sc && !$past(cmp.over_sc) && !oc_hit &&
                                !cmp.chg_over_oc && !cmp.dis_over_oc |=> !o_fet_off [*2])
      else $error("FET off without qualified excursion");
   hash_a: assert property (i_rd_en && (i_addr == `ADDR_FEATURE) |=>
                            (o_rdata[`FEATURE_HASH_BIT] == (TWO_WIRE && $past(i_hash_busy))))
      else $error("hash status misreported");
   pin_drive_a: assert property (##1 o_general_pin_oe == !$past(gpin_ctl_q))
      else $error("general pin drive does not follow control");
   sleep_pin_a: assert property ((state_q == ST_SLEEP) |-> gpin_ctl_q)
      else $error("pin control not released in sleep");
   copy_a: assert property ((state_q == ST_ACTIVE) && i_copy |=> (nv_ctrl_q == $past(ctrl_q)))
      else $error("copy did not reach nonvolatile image");

   sleep_c: cover property ((state_q == ST_ACTIVE) ##1 (state_q == ST_SLEEP) ##[1:1000] (state_q == ST_ACTIVE));
   ov_c: cover property ($rose(o_ov_flag));
   fet_c: cover property ($rose(o_fet_off));
   recall_c: cover property ((state_q == ST_ACTIVE) && i_recall && (nv_ctrl_q != ctrl_q));
endmodule : battery_protector_config

//--- hw/bpc_cfg.svh
/*
 * Offsets, field positions, reset values and cycle counts of the protector configuration bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH

// register byte addresses
`define ADDR_FEATURE 8'h15
`define ADDR_CONTROL 8'h60
`define ADDR_SENSE_GAIN 8'h78
`define ADDR_OV_THRESH 8'h7F

// special feature register field positions
`define FEATURE_HASH_BIT 1
`define FEATURE_GPIN_BIT 0

// nonvolatile images after power-up, and other reset values
`define CONTROL_NV_RST 8'h00
`define SENSE_GAIN_NV_RST 8'h00
`define OV_THRESH_NV_RST 7'h00
`define GPIN_CTL_RST 1'b1

// values returned and produced
`define UNMAPPED_READ 8'hFF
`define NET_ADDR_OPCODE_0 8'h33
`define NET_ADDR_OPCODE_1 8'h39

// qualifying delays in cycles of the 100 MHz clock
`define SLEEP_DLY_CYC 8192
`define OV_DLY_CYC 1024
`define OC_DLY_CYC 512
`define SC_DLY_CYC 32

// negative current readings at or above minus this count are blanked
`define BLANK_LIMIT 16'h0010

`endif

//--- hw/bpc_persist.sv
/*
 * Persistence counter: reports a condition once it has held for DELAY cycles.
 * Assumes the condition comes from the core clock domain.
 */
`timescale 1ns/1ns
module bpc_persist #(
   parameter int DELAY = 16
) (
   input wire logic i_core_clk,  // core clock
   input wire logic i_rstn,      // async reset, active low
   input wire logic i_cond,      // qualifying condition
   output logic o_hit            // condition held for DELAY cycles
);
   localparam int CW = $clog2(DELAY + 1);
   localparam logic [CW-1:0] LIMIT = CW'(DELAY);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // count while held, restart when the condition drops
   always_comb
   begin
      if (!i_cond)
         cnt_d = '0;
      else if (cnt_q == LIMIT)
         cnt_d = cnt_q;
      else
         cnt_d = cnt_q + 1'b1;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign o_hit = i_cond && (cnt_q == LIMIT);
endmodule : bpc_persist

//--- hw/bpc_pkg.sv
/*
 * Types shared by the protector configuration bank.
 * Assumes bpc_cfg.svh is on the include path.
 */
package bpc_pkg;
   `include "bpc_cfg.svh"

   // control register layout, bit 7 first
   typedef struct packed {
      logic negative_blank_en;
      logic undervoltage_sleep_en;
      logic line_low_sleep_en;
      logic net_addr_opcode_sel;
      logic [1:0] uv_threshold_sel;
      logic gpin_power_switch_en;
      logic line_power_switch_en;
   } ctrl_s;

   // sense gain register upper bits, remainder kept as gain data
   typedef struct packed {
      logic [1:0] overcurrent_sel;
      logic short_circuit_sel;
      logic [4:0] gain_bits;
   } sense_gain_s;

   // analog comparator outcomes
   typedef struct packed {
      logic cell1_input_over;
      logic cell2_input_over;
      logic avg_under_uv;
      logic chg_over_oc;
      logic dis_over_oc;
      logic over_sc;
   } cmp_s;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_SLEEP = 3'b100
   } pwr_state_e;
endpackage : bpc_pkg

//--- hw/bpc_sync2.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous inputs.
 * Assumes each bit is an independent level.
 */
`timescale 1ns/1ns
module bpc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic i_core_clk,           // core clock
   input wire logic i_rstn,               // async reset, active low
   input wire logic [WIDTH-1:0] i_async,  // asynchronous levels
   output logic [WIDTH-1:0] o_sync        // synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : bpc_sync2

//--- verification/bpc_host.sv
/*
 * Host-side partner: byte reads and writes on the register port, and the
 * pulled-up open-drain general pin wire.
 * Assumes its tasks are entered just after a falling clock edge.
 */
`timescale 1ns/1ns
module bpc_host (
   input wire logic i_core_clk,   // core clock
   input wire logic [7:0] i_rdata, // read data
   input wire logic i_rvalid,     // read data valid
   input wire logic i_pin_oe,     // device pulls pin low
   output logic o_wr_en,          // write strobe
   output logic o_rd_en,          // read strobe
   output logic [7:0] o_addr,     // byte address
   output logic [7:0] o_wdata,    // write data
   output logic o_pin             // resolved pin level
);
   // open drain with external pull-up
   assign o_pin = i_pin_oe ? 1'b0 : 1'b1;

   // idle bus at time zero
   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end

   // one-cycle write strobe; a feature write loads pin control from data bit 0 whether
   // or not the general pin power switch is on
   task wr(input logic [7:0] a, input logic [7:0] d);
      begin
         o_addr = a;
         o_wdata = d;
         o_wr_en = 1'b1;
         @(negedge i_core_clk);
         o_wr_en = 1'b0;
         o_addr = ~a;
         o_wdata = ~d;
         // idle cycle keeps back-to-back calls from re-driving the bus in one step
         @(negedge i_core_clk);
      end
   endtask : wr

   // one-cycle read strobe, data taken when valid shows
   task rd(input logic [7:0] a, output logic [7:0] d);
      begin
         o_addr = a;
         o_rd_en = 1'b1;
         @(negedge i_core_clk);
         o_rd_en = 1'b0;
         o_addr = ~a;
         d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
         // idle cycle keeps back-to-back calls from re-driving the bus in one step
         @(negedge i_core_clk);
      end
   endtask : rd
endmodule : bpc_host

//--- verification/tb_top.sv
/*
 * Self-checking bench for the protector configuration bank.
 * Assumes the design package and shortened delay parameters; the main copy is
 * single-wire and a second two-wire copy shares every input.
 */
`timescale 1ns/1ns
module tb_top;
   import bpc_pkg::*;
   localparam int SD = 8;
   localparam int OVD = 6;
   localparam int OCD = 5;
   localparam int SCD = 3;
   logic clk, rstn, copy, recall, hash, line, wr, rd, pin, oe, rv, slp, ovf, fet, seen;
   logic [7:0] addr, wd, rdat, opc, d, rdat2;
   logic [15:0] cur, ocur;
   logic [5:0] cv;
   logic [1:0] uvs, ocs;
   logic [6:0] ovt;
   logic scs, gpe, lpe, pin_o, lpe2;
   int fails, checked, k, i, e, m_ctl, m_sg, m_ov;
   int bits[5] = '{5, 4, 2, 1, 0};
   int dls[5] = '{OVD, OVD, OCD, OCD, SCD};

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   battery_protector_config #(.SLEEP_DLY(SD), .OV_DLY(OVD), .OC_DLY(OCD), .SC_DLY(SCD)) dut (
      .i_core_clk(clk), .i_rstn(rstn), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
      .i_wdata(wd), .i_copy(copy), .i_recall(recall), .i_hash_busy(hash), .i_current(cur),
      .i_line(line), .i_general_pin(pin), .i_cmp(cmp_s'(cv)), .o_rdata(rdat), .o_rvalid(rv),
      .o_current(ocur), .o_net_addr_opcode(opc), .o_uv_threshold_sel(uvs), .o_ov_threshold(ovt),
      .o_overcurrent_sel(ocs), .o_short_circuit_sel(scs), .o_gpin_power_switch_en(gpe),
      .o_line_power_switch_en(lpe), .o_general_pin_o(pin_o), .o_general_pin_oe(oe),
      .o_sleep(slp), .o_ov_flag(ovf), .o_fet_off(fet));

   // two-wire build on the same bus; only its read data and line switch enable are watched
   battery_protector_config #(.TWO_WIRE(1'b1), .SLEEP_DLY(SD), .OV_DLY(OVD), .OC_DLY(OCD), .SC_DLY(SCD)) dut2 (
      .i_core_clk(clk), .i_rstn(rstn), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
      .i_wdata(wd), .i_copy(copy), .i_recall(recall), .i_hash_busy(hash), .i_current(cur),
      .i_line(line), .i_general_pin(pin), .i_cmp(cmp_s'(cv)), .o_rdata(rdat2), .o_rvalid(),
      .o_current(), .o_net_addr_opcode(), .o_uv_threshold_sel(), .o_ov_threshold(),
      .o_overcurrent_sel(), .o_short_circuit_sel(), .o_gpin_power_switch_en(),
      .o_line_power_switch_en(lpe2), .o_general_pin_o(), .o_general_pin_oe(),
      .o_sleep(), .o_ov_flag(), .o_fet_off());

   bpc_host host (.i_core_clk(clk), .i_rdata(rdat), .i_rvalid(rv), .i_pin_oe(oe), .o_wr_en(wr),
      .o_rd_en(rd), .o_addr(addr), .o_wdata(wd), .o_pin(pin));

   // verdict and end of run
   task close_out;
      begin
         $display("checked %0d fails %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask : close_out

   // compare one result against the model
   task chk(input logic [15:0] got, input logic [15:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask : chk

   // a bounded wait that ran out ends the run
   task lim;
      begin
         if (k >= 40)
         begin
            fails++;
            $display("[FAIL] %0t wait ran out", $time);
            close_out();
         end
      end
   endtask : lim

   task rdc(input logic [7:0] a, input logic [7:0] exp);
      begin
         host.rd(a, d);
         chk(d, exp);
      end
   endtask : rdc

   // protection output for table entry j
   function automatic logic fl(input int j);
      return (j < 2) ? ovf : fet;
   endfunction : fl

   initial
   begin
      copy = 1'b0;
      recall = 1'b0;
      hash = 1'b0;
      cur = 16'h0000;
      line = 1'b1;
      cv = 6'h00;
      fails = 0;
      checked = 0;
      rstn = 1'b0;
      void'($urandom(32'hB9EFBF8D));
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      // power-up values
      rdc(8'h60, 8'h00);
      rdc(8'h7F, 8'h00);
      rdc(8'h15, 8'h01);
      rdc(8'h42, 8'hFF);
      chk(opc, 8'h33);
      chk(oe, 1'b0);
      $display("test reset done");
      // control fields, every threshold code
      for (i = 0; i < 8; i++)
      begin
         m_ctl = ($urandom & 8'h93) | ((i % 4) << 2);
         host.wr(8'h60, m_ctl[7:0]);
         rdc(8'h60, m_ctl[7:0]);
         @(negedge clk);
         chk(opc, m_ctl[4] ? 8'h39 : 8'h33);
         chk(uvs, m_ctl[3:2]);
         chk(gpe, m_ctl[1]);
         chk(lpe, m_ctl[0]);
         chk(lpe2, 1'b0);
      end
      $display("test control done");
      // shadow against nonvolatile image
      host.wr(8'h60, 8'h91);
      copy = 1'b1;
      @(negedge clk);
      copy = 1'b0;
      host.wr(8'h60, 8'h02);
      rdc(8'h60, 8'h02);
      recall = 1'b1;
      @(negedge clk);
      recall = 1'b0;
      rdc(8'h60, 8'h91);
      $display("test copy recall done");
      // threshold registers
      for (i = 0; i < 4; i++)
      begin
         m_ov = $urandom | 8'h80;
         m_sg = (i << 6) | ((i & 1) << 5) | ($urandom & 8'h1F);
         host.wr(8'h7F, m_ov[7:0]);
         host.wr(8'h78, m_sg[7:0]);
         rdc(8'h7F, {1'b0, m_ov[6:0]});
         rdc(8'h78, m_sg[7:0]);
         @(negedge clk);
         chk(ovt, m_ov[6:0]);
         chk(ocs, m_sg[7:6]);
         chk(scs, m_sg[5]);
      end
      $display("test thresholds done");
      // negative current blanking at the limit and past it
      for (i = 0; i < 6; i++)
      begin
         m_ctl = (i < 3) ? 8'h80 : 8'h00;
         host.wr(8'h60, m_ctl[7:0]);
         @(negedge clk);
         k = (i % 3 == 0) ? -16 : (i % 3 == 1) ? -17 : -($urandom % 16);
         cur = k[15:0];
         @(negedge clk);
         e = (m_ctl[7] && k < 0 && k >= -16) ? 0 : k;
         chk(ocur, e[15:0]);
      end
      $display("test blanking done");
      // pin control on the single-wire build, hash bit on both builds
      host.wr(8'h60, 8'h00);
      hash = 1'b1;
      host.wr(8'h15, 8'h00);
      repeat (6) @(negedge clk);
      chk(oe, 1'b1);
      chk(pin_o, 1'b0);
      rdc(8'h15, 8'h00);
      chk(rdat2, 8'h02);
      host.wr(8'h15, 8'h01);
      repeat (6) @(negedge clk);
      chk(oe, 1'b0);
      rdc(8'h15, 8'h01);
      chk(rdat2, 8'h03);
      hash = 1'b0;
      rdc(8'h15, 8'h01);
      chk(rdat2, 8'h01);
      $display("test pin done");
      // short excursions ignored, long ones qualified
      for (i = 0; i < 5; i++)
      begin
         seen = 1'b0;
         cv[bits[i]] = 1'b1;
         for (k = 0; k < dls[i] + 8; k++)
         begin
            if (k == dls[i] - 2)
               cv[bits[i]] = 1'b0;
            @(negedge clk);
            seen = seen | fl(i);
         end
         chk(seen, 1'b0);
         cv[bits[i]] = 1'b1;
         for (k = 0; k < 40 && fl(i) !== 1'b1; k++)
            @(negedge clk);
         lim();
         chk(k >= dls[i] && k <= dls[i] + 4, 1'b1);
         cv[bits[i]] = 1'b0;
         repeat (6) @(negedge clk);
         chk(fl(i), 1'b0);
      end
      $display("test protection done");
      // line-low sleep releases the pin and refuses writes
      host.wr(8'h15, 8'h00);
      host.wr(8'h60, 8'h20);
      line = 1'b0;
      for (k = 0; k < 40 && slp !== 1'b1; k++)
         @(negedge clk);
      lim();
      chk(k >= SD, 1'b1);
      chk(oe, 1'b0);
      host.wr(8'h60, 8'h00);
      line = 1'b1;
      for (k = 0; k < 40 && slp !== 1'b0; k++)
         @(negedge clk);
      lim();
      repeat (2) @(negedge clk);
      rdc(8'h60, 8'h20);
      rdc(8'h15, 8'h01);
      // undervoltage sleep only when enabled
      host.wr(8'h60, 8'h00);
      cv[3] = 1'b1;
      repeat (SD + 8) @(negedge clk);
      chk(slp, 1'b0);
      host.wr(8'h60, 8'h40);
      for (k = 0; k < 40 && slp !== 1'b1; k++)
         @(negedge clk);
      lim();
      chk(slp, 1'b1);
      cv[3] = 1'b0;
      line = 1'b0;
      repeat (SD + 8) @(negedge clk);
      chk(slp, 1'b0);
      line = 1'b1;
      $display("test sleep done");
      close_out();
   end
endmodule : tb_top
